/* File: rtl/tsr_pkg.sv */
// Shared constants and types for the terminal signal routing block
`default_nettype none
package tsr_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int N_DI = 6;
	localparam int N_IN = 7;
	localparam int N_CMD = 8;
	localparam int N_DO = 3;
	localparam int AW = 6;
	localparam int DW = 16;
	localparam int CW = 16;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
	// ------------------------------------------------------------
	// Register indices (word addresses)
	// ------------------------------------------------------------
	localparam logic [AW-1:0] REG_INPUT_STATUS = 6'h00;
	localparam logic [AW-1:0] REG_DRV_STATUS = 6'h01;
	localparam logic [AW-1:0] REG_DRV_STATUS_TWO = 6'h02;
	localparam logic [AW-1:0] REG_PRESET = 6'h03;
	localparam logic [AW-1:0] REG_DEBOUNCE = 6'h04;
	localparam logic [AW-1:0] REG_OUT_INVERT = 6'h05;
	localparam logic [AW-1:0] REG_SAFE_CTRL = 6'h06;
	localparam logic [AW-1:0] REG_DISC_TOL = 6'h07;
	localparam logic [AW-1:0] REG_IRQ_STATUS = 6'h08;
	localparam logic [AW-1:0] REG_IRQ_CLEAR = 6'h09;
	localparam logic [AW-1:0] REG_IRQ_ENABLE = 6'h0A;
	localparam logic [AW-1:0] REG_CMD_SRC_BASE = 6'h10;
	localparam logic [AW-1:0] REG_OUT_SRC_BASE = 6'h18;
	// ------------------------------------------------------------
	// Fields, encodings and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] SRC_WORD_OFF = 4'h0;
	localparam logic [3:0] SRC_WORD_IN = 4'h1;
	localparam logic [3:0] SRC_WORD_DRV = 4'h2;
	localparam logic [3:0] SRC_WORD_DRV_TWO = 4'h3;
	localparam logic [3:0] DRV_FAULT_BIT = 4'h3;
	localparam logic [7:0] PRESET_FAILSAFE = 8'h02;
	localparam logic [7:0] PRESET_RST = 8'h00;
	localparam int SAFE_A = 4;
	localparam int SAFE_B = 5;
	localparam int SAFE_CTRL_STO_EN = 0;
	localparam int EV_DISCREPANCY = 0;
	localparam int EV_STO_SELECT = 1;
	localparam int EV_INPUT_CHANGE = 2;
	localparam int N_EV = 3;
	localparam logic [CW-1:0] DEBOUNCE_RST = 16'h0003;
	localparam logic [CW-1:0] DISC_TOL_RST = 16'h01F4;
	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] word;
		logic [3:0] bitn;
	} tsr_sel_t;
	localparam tsr_sel_t SEL_OFF = '{word: SRC_WORD_OFF, bitn: 4'h0};
	localparam tsr_sel_t SEL_DRV_FAULT = '{word: SRC_WORD_DRV, bitn: DRV_FAULT_BIT};
	typedef struct packed {
		logic [15:0] drv;
		logic [15:0] drv_two;
	} tsr_status_t;
endpackage
`default_nettype wire

/* File: rtl/tsr_routing.sv */
// Terminal signal routing: input sampling, command/output routing, fail-safe pair
//
// Contract
// RULE1 - Terminal writes replace preset routing
// RULE2 - Every command sink has a source selector
// RULE3 - Selector is word number plus bit index
// RULE4 - Configurable debounce on digital inputs
// RULE5 - Analog input usable as extra digital input
// RULE6 - Preset two pairs inputs four, five
// RULE7 - Both safe channels same level, high deselects
// RULE8 - Channel mismatch raises a fault
// RULE9 - Safe torque off needs configuration enable
// RULE10 - Output selector; zero holds output inactive
// RULE11 - Drive fault bit routable to output
// RULE12 - Per-output inversion of routed bit
// RULE13 - Mismatch flagged after tolerance time only
//
// The implementer's own choices: the plain strobed port and the register offsets.
`default_nettype none
module tsr_routing
	import tsr_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Register port
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	// Terminal pins
	input wire logic [N_DI-1:0] terminal_in,
	input wire logic analog_in_digital,
	output logic [N_DO-1:0] terminal_out,
	// Drive side
	input wire tsr_status_t drive_status,
	output logic [N_CMD-1:0] drive_cmd,
	output logic safe_torque_off,
	output logic safe_input_fault,
	output logic irq
);
	// ------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------
	function automatic logic pick_bit(input tsr_sel_t sel, input logic [N_IN-1:0] inw,
		input tsr_status_t st);
		logic r;
		r = 1'b0;
		case (sel.word) // RULE3
			SRC_WORD_IN:
				if (int'(sel.bitn) < N_IN)
					r = inw[sel.bitn[2:0]];
			SRC_WORD_DRV:
				r = st.drv[sel.bitn]; // RULE11
			SRC_WORD_DRV_TWO:
				r = st.drv_two[sel.bitn];
			default:
				r = 1'b0; // RULE10
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// Register write decode
	// ------------------------------------------------------------
	logic wr_en;
	logic rd_en;
	assign wr_en = ce & reg_wr;
	assign rd_en = ce & reg_rd;

	logic [7:0] preset_r;
	logic [CW-1:0] debounce_r;
	logic [N_DO-1:0] out_invert_r;
	logic sto_enable_r;
	logic [CW-1:0] disc_tol_r;
	logic [N_EV-1:0] irq_status_r;
	logic [N_EV-1:0] irq_enable_r;
	tsr_sel_t cmd_src_r [N_CMD];
	tsr_sel_t out_src_r [N_DO];
	logic preset_load;
	assign preset_load = wr_en && reg_addr == REG_PRESET;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			preset_r <= PRESET_RST;
			debounce_r <= DEBOUNCE_RST;
			out_invert_r <= '0;
			sto_enable_r <= 1'b0;
			disc_tol_r <= DISC_TOL_RST;
			irq_enable_r <= '0;
		end
		else if (wr_en)
		begin
			case (reg_addr)
				REG_PRESET:
					preset_r <= reg_wdata[7:0];
				REG_DEBOUNCE:
					debounce_r <= reg_wdata;
				REG_OUT_INVERT:
					out_invert_r <= reg_wdata[N_DO-1:0];
				REG_SAFE_CTRL:
					sto_enable_r <= reg_wdata[SAFE_CTRL_STO_EN];
				REG_DISC_TOL:
					disc_tol_r <= reg_wdata;
				REG_IRQ_ENABLE:
					irq_enable_r <= reg_wdata[N_EV-1:0];
				default:
					;
			endcase
		end
	end

	// Preset write reloads the output map, and the command map only if its value changes; a later selector write overrides one entry
	genvar gi;
	generate
		for (gi = 0; gi < N_CMD; gi++)
		begin : g_cmd_src
			tsr_sel_t def_sel;
			always_comb
			begin
				def_sel = SEL_OFF;
				if (gi < N_DI)
					def_sel = '{word: SRC_WORD_IN, bitn: 4'(gi)};
				if ((gi == SAFE_A || gi == SAFE_B) && preset_r == PRESET_FAILSAFE)
					def_sel = SEL_OFF;
			end
			always_ff @(posedge clk)
			begin
				if (!rstn)
					cmd_src_r[gi] <= '{word: SRC_WORD_IN, bitn: 4'(gi % N_DI)};
				else if (wr_en && reg_addr == REG_CMD_SRC_BASE + AW'(gi))
					cmd_src_r[gi] <= tsr_sel_t'(reg_wdata[7:0]); // RULE1 RULE2
				else if (preset_load && reg_wdata[7:0] != preset_r)
					cmd_src_r[gi] <= def_sel;
			end
		end
		for (gi = 0; gi < N_DO; gi++)
		begin : g_out_src
			always_ff @(posedge clk)
			begin
				if (!rstn)
					out_src_r[gi] <= (gi == 0) ? SEL_DRV_FAULT : SEL_OFF;
				else if (wr_en && reg_addr == REG_OUT_SRC_BASE + AW'(gi))
					out_src_r[gi] <= tsr_sel_t'(reg_wdata[7:0]); // RULE1 RULE10
				else if (preset_load)
					out_src_r[gi] <= (gi == 0) ? SEL_DRV_FAULT : SEL_OFF;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Microsecond tick for debounce and tolerance timing
	// ------------------------------------------------------------
	logic [7:0] tick_cnt_r;
	logic tick;
	assign tick = ce && tick_cnt_r == TICK_LAST;
	always_ff @(posedge clk)
	begin
		if (!rstn)
			tick_cnt_r <= '0;
		else if (ce)
			tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
	end

	// ------------------------------------------------------------
	// Input sampling and debounce
	// ------------------------------------------------------------
	logic [N_IN-1:0] pin_all;
	logic [N_IN-1:0] in_filt_r;
	assign pin_all = {analog_in_digital, terminal_in}; // RULE5
	generate
		for (gi = 0; gi < N_IN; gi++)
		begin : g_in
			logic [2:0] sync_r;
			logic lvl_r;
			logic [CW-1:0] cnt_r;
			always_ff @(posedge clk)
			begin
				if (!rstn)
				begin
					sync_r <= '0;
					lvl_r <= 1'b0;
				end
				else if (ce)
				begin
					sync_r <= {sync_r[1:0], pin_all[gi]};
					if (sync_r[1] == sync_r[2])
						lvl_r <= sync_r[2];
				end
			end
			// Counts ticks while the level differs from the filtered one; the first may come after part of a tick
			always_ff @(posedge clk)
			begin
				if (!rstn)
				begin
					cnt_r <= '0;
					in_filt_r[gi] <= 1'b0;
				end
				else if (ce)
				begin
					if (lvl_r == in_filt_r[gi])
						cnt_r <= '0;
					else if (cnt_r >= debounce_r)
					begin
						in_filt_r[gi] <= lvl_r; // RULE4
						cnt_r <= '0;
					end
					else if (tick)
						cnt_r <= cnt_r + 16'h0001;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Fail-safe input pair
	// ------------------------------------------------------------
	logic fs_mode;
	logic chan_a;
	logic chan_b;
	logic [CW-1:0] disc_cnt_r;
	logic disc_fault_r;
	logic sto_sel_r;
	assign fs_mode = preset_r == PRESET_FAILSAFE; // RULE6
	assign chan_a = in_filt_r[SAFE_A];
	assign chan_b = in_filt_r[SAFE_B];

	// Short skew between contacts is normal; only a lasting mismatch is a fault
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			disc_cnt_r <= '0;
			disc_fault_r <= 1'b0;
		end
		else if (ce)
		begin
			if (!fs_mode || chan_a == chan_b)
			begin
				disc_cnt_r <= '0;
				disc_fault_r <= 1'b0;
			end
			else if (disc_cnt_r >= disc_tol_r)
				disc_fault_r <= 1'b1; // RULE8 RULE13
			else if (tick)
				disc_cnt_r <= disc_cnt_r + 16'h0001; // RULE13
		end
	end

	// Low on either channel selects; a mismatch also fails safe
	always_ff @(posedge clk)
	begin
		if (!rstn)
			sto_sel_r <= 1'b0;
		else if (ce)
			sto_sel_r <= fs_mode && sto_enable_r && !(chan_a && chan_b); // RULE7 RULE9
	end

	// ------------------------------------------------------------
	// Command and output routing
	// ------------------------------------------------------------
	logic [N_CMD-1:0] cmd_r;
	logic [N_DO-1:0] dout_r;
	generate
		for (gi = 0; gi < N_CMD; gi++)
		begin : g_cmd
			always_ff @(posedge clk)
			begin
				if (!rstn)
					cmd_r[gi] <= 1'b0;
				else if (ce)
					cmd_r[gi] <= pick_bit(cmd_src_r[gi], in_filt_r, drive_status); // RULE2
			end
		end
		for (gi = 0; gi < N_DO; gi++)
		begin : g_do
			always_ff @(posedge clk)
			begin
				if (!rstn)
					dout_r[gi] <= 1'b0;
				else if (ce)
					dout_r[gi] <= (out_src_r[gi] != SEL_OFF) &&
						(pick_bit(out_src_r[gi], in_filt_r, drive_status)
						^ out_invert_r[gi]); // RULE10 RULE12
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Events and interrupt
	// ------------------------------------------------------------
	logic [N_IN-1:0] in_prev_r;
	logic disc_prev_r;
	logic sto_prev_r;
	logic [N_EV-1:0] ev;
	logic [N_EV-1:0] clr;
	logic irq_r;
	always_comb
	begin
		ev = '0;
		ev[EV_DISCREPANCY] = disc_fault_r && !disc_prev_r;
		ev[EV_STO_SELECT] = sto_sel_r && !sto_prev_r;
		ev[EV_INPUT_CHANGE] = in_filt_r != in_prev_r;
	end
	assign clr = (wr_en && reg_addr == REG_IRQ_CLEAR) ? reg_wdata[N_EV-1:0] : '0;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			in_prev_r <= '0;
			disc_prev_r <= 1'b0;
			sto_prev_r <= 1'b0;
			irq_status_r <= '0;
			irq_r <= 1'b0;
		end
		else if (ce)
		begin
			in_prev_r <= in_filt_r;
			disc_prev_r <= disc_fault_r;
			sto_prev_r <= sto_sel_r;
			// Set beats clear in the same cycle
			irq_status_r <= (irq_status_r & ~clr) | ev;
			irq_r <= |(((irq_status_r & ~clr) | ev) & irq_enable_r);
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	logic [DW-1:0] rdata_r;
	logic [DW-1:0] rd_mux;
	always_comb
	begin
		rd_mux = '0;
		if (reg_addr >= REG_CMD_SRC_BASE && reg_addr < REG_CMD_SRC_BASE + AW'(N_CMD))
			rd_mux[7:0] = cmd_src_r[3'(reg_addr - REG_CMD_SRC_BASE)];
		else if (reg_addr >= REG_OUT_SRC_BASE && reg_addr < REG_OUT_SRC_BASE + AW'(N_DO))
			rd_mux[7:0] = out_src_r[2'(reg_addr - REG_OUT_SRC_BASE)];
		else
		begin
			case (reg_addr)
				REG_INPUT_STATUS:
					rd_mux[N_IN-1:0] = in_filt_r;
				REG_DRV_STATUS:
					rd_mux = drive_status.drv;
				REG_DRV_STATUS_TWO:
					rd_mux = drive_status.drv_two;
				REG_PRESET:
					rd_mux[7:0] = preset_r;
				REG_DEBOUNCE:
					rd_mux = debounce_r;
				REG_OUT_INVERT:
					rd_mux[N_DO-1:0] = out_invert_r;
				REG_SAFE_CTRL:
					rd_mux[SAFE_CTRL_STO_EN] = sto_enable_r;
				REG_DISC_TOL:
					rd_mux = disc_tol_r;
				REG_IRQ_STATUS:
					rd_mux[N_EV-1:0] = irq_status_r;
				REG_IRQ_ENABLE:
					rd_mux[N_EV-1:0] = irq_enable_r;
				default:
					rd_mux = '0;
			endcase
		end
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rdata_r <= '0;
		else if (ce)
			rdata_r <= rd_en ? rd_mux : '0;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata = rdata_r;
	assign terminal_out = dout_r;
	assign drive_cmd = cmd_r;
	assign safe_torque_off = sto_sel_r;
	assign safe_input_fault = disc_fault_r;
	assign irq = irq_r;
endmodule
`default_nettype wire

/* File: sim/tsr_routing_chk.sv */
// Assertion checker for the terminal signal routing block
`default_nettype none
module tsr_routing_chk
	import tsr_pkg::*;
(
	// Clock and register port
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DW-1:0] reg_rdata,
	// Watched outputs and the drive status input
	input wire logic [N_DO-1:0] terminal_out,
	input wire tsr_status_t drive_status,
	input wire logic safe_torque_off,
	input wire logic safe_input_fault,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] preset_r;
	logic sto_en_r;
	logic irq_en_r;
	logic dflt_r;
	wire logic pair_on = preset_r == PRESET_FAILSAFE;
	wire logic armed = pair_on && sto_en_r;
	// ----
	// Bus shadow
	// ----
	always_ff @(posedge clk)
	begin
		if (ce && !rstn)
		begin
			preset_r <= PRESET_RST;
			sto_en_r <= 1'b0;
			irq_en_r <= 1'b0;
			dflt_r <= 1'b1;
		end
		else if (ce && reg_wr)
		begin
			case (reg_addr)
				REG_PRESET: preset_r <= reg_wdata[7:0];
				REG_SAFE_CTRL: sto_en_r <= reg_wdata[SAFE_CTRL_STO_EN];
				REG_IRQ_ENABLE: irq_en_r <= |reg_wdata[N_EV-1:0];
				default: ;
			endcase
			// Any output config write ends the default routing view
			if (reg_addr == REG_PRESET || reg_addr == REG_OUT_INVERT || reg_addr[5:3] == 3'h3)
				dflt_r <= 1'b0;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ----
	// Properties
	// ----
	a_out_fault_bit: assert property (
		dflt_r && $past(dflt_r) && $past(rstn) && $past(ce)
		|-> terminal_out[0] == $past(drive_status.drv[3])) else $error("out0 not fault bit");
	a_out_off_low: assert property (
		dflt_r && $past(dflt_r) |-> terminal_out[2:1] == 2'h0) else $error("off output high");
	a_sto_needs_en: assert property (
		!armed && !$past(armed) |-> !safe_torque_off) else $error("sto without enable");
	a_fault_needs_pair: assert property (
		!pair_on && !$past(pair_on) |-> !safe_input_fault) else $error("fault outside pair");
	a_fault_selects: assert property (
		armed && $past(armed) && safe_input_fault && $past(safe_input_fault)
		|-> safe_torque_off) else $error("fault without sto");
	a_irq_masked: assert property (
		!irq_en_r && !$past(irq_en_r) |-> !irq) else $error("irq while masked");
	a_clear_reads_zero: assert property (
		ce && reg_rd && reg_addr == REG_IRQ_CLEAR |=> reg_rdata == 16'h0000) else $error("clr rd");
	a_preset_readback: assert property (
		ce && reg_rd && reg_addr == REG_PRESET |=> reg_rdata == {8'h00, preset_r})
		else $error("preset readback");
	a_status_width: assert property (
		ce && reg_rd && reg_addr == REG_INPUT_STATUS |=> reg_rdata[15:7] == 9'h000)
		else $error("status reserved bits");
	a_rdata_idle: assert property (
		$past(ce) && !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
	c_sto: cover property (armed && safe_torque_off);
	c_fault: cover property ($rose(safe_input_fault));
	c_irq: cover property (irq && irq_en_r);
endmodule
bind tsr_routing tsr_routing_chk u_chk (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.terminal_out(terminal_out), .drive_status(drive_status), .safe_torque_off(safe_torque_off),
	.safe_input_fault(safe_input_fault), .irq(irq));
`default_nettype wire

/* File: sim/tsr_field.sv */
// Field-side model: switches, sensor pair and analog level
`default_nettype none
module tsr_field
(
	// Clock and bench commands
	input wire logic clk,
	input wire logic [6:0] lvl,
	input wire logic pair,
	input wire logic brk,
	input wire logic [5:0] skew,
	// Terminal pins
	output logic [5:0] pins,
	output logic ana
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] dly_r;
	always_ff @(posedge clk)
	begin
		dly_r <= {dly_r[62:0], lvl[4]};
		pins[4:0] <= lvl[4:0];
		ana <= lvl[6];
		// Sensor pair shows one level with skew; a cut cable reads low
		pins[5] <= pair ? dly_r[skew] & !brk : lvl[5];
	end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking testbench for the terminal signal routing block
`default_nettype none
module testbench
	import tsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic [AW-1:0] reg_addr = '0;
	logic [DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DW-1:0] reg_rdata;
	logic [N_DI-1:0] terminal_in;
	logic analog_in_digital;
	logic [N_DO-1:0] terminal_out;
	tsr_status_t drive_status = '0;
	logic [N_CMD-1:0] drive_cmd;
	logic safe_torque_off;
	logic safe_input_fault;
	logic irq;
	logic [6:0] lvl = '0;
	logic pair = 1'b0;
	logic brk = 1'b0;
	logic [5:0] skew = '0;
	logic [6:0] v;
	logic [2:0] inv;
	int n_mismatch = 0;
	int samples_checked = 0;
	tsr_routing uut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.terminal_in(terminal_in), .analog_in_digital(analog_in_digital),
		.terminal_out(terminal_out), .drive_status(drive_status), .drive_cmd(drive_cmd),
		.safe_torque_off(safe_torque_off), .safe_input_fault(safe_input_fault), .irq(irq));
	tsr_field u_fld (.clk(clk), .lvl(lvl), .pair(pair), .brk(brk), .skew(skew),
		.pins(terminal_in), .ana(analog_in_digital));
	initial
	begin
		forever #4 clk = ~clk;
	end
	// ----
	// Expectations and bus tasks
	// ----
	function automatic logic [2:0] exp_out(tsr_status_t s, logic [2:0] iv, logic s1);
		return {1'b0, s1 & (s.drv_two[5] ^ iv[1]), s.drv[3] ^ iv[0]};
	endfunction
	function automatic logic [7:0] exp_cmd(logic [6:0] s);
		return {s[1:0], s[5:2], s[6], s[1]};
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [5:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(nm, reg_rdata, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic complete_run;
		$display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_mismatch++;
		complete_run();
	end
	// ----
	// Main sequence
	// ----
	initial
	begin
		void'($urandom(92613));
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rdc("preset", REG_PRESET, 16'h0000);
		rdc("debounce", REG_DEBOUNCE, DEBOUNCE_RST);
		rdc("tolerance", REG_DISC_TOL, DISC_TOL_RST);
		rdc("out0 src", REG_OUT_SRC_BASE, 16'h0023);
		rdc("unmapped", 6'h3F, 16'h0000);
		rdc("clear wo", REG_IRQ_CLEAR, 16'h0000);
		ce <= 1'b0;
		wr(REG_DEBOUNCE, 16'h0005);
		ce <= 1'b1;
		rdc("ce freeze", REG_DEBOUNCE, DEBOUNCE_RST);
		wr(REG_INPUT_STATUS, 16'hFFFF);
		rdc("status ro", REG_INPUT_STATUS, 16'h0000);
		$display("Test reset values done");
		for (int i = 0; i < 12; i++)
		begin
			inv = 3'($urandom());
			if (i == 6)
				wr(REG_OUT_SRC_BASE + 6'h01, 16'h0035);
			wr(REG_OUT_INVERT, {13'h0000, inv});
			drive_status <= 32'($urandom());
			wt(3);
			chk("outputs", 16'(terminal_out), 16'(exp_out(drive_status, inv, i >= 6)));
		end
		$display("Test output routing done");
		wr(REG_DEBOUNCE, 16'h0000);
		wr(REG_CMD_SRC_BASE, 16'h0011);
		wr(REG_CMD_SRC_BASE + 6'h01, 16'h0016);
		for (int i = 0; i < 8; i++)
		begin
			v = (i == 7) ? 7'h00 : 7'($urandom());
			lvl <= v;
			wt(12);
			rdc("in status", REG_INPUT_STATUS, {9'h000, v});
			chk("commands", 16'(drive_cmd), 16'(exp_cmd(v)));
		end
		wr(REG_DEBOUNCE, 16'h0002);
		// Under one tick long, so at most one tick is counted
		lvl <= 7'h04;
		wt(100);
		lvl <= 7'h00;
		wt(400);
		rdc("glitch", REG_INPUT_STATUS, 16'h0000);
		lvl <= 7'h04;
		wt(100);
		rdc("early", REG_INPUT_STATUS, 16'h0000);
		wt(260);
		rdc("late", REG_INPUT_STATUS, 16'h0004);
		$display("Test input routing done");
		wr(REG_DEBOUNCE, 16'h0000);
		wr(REG_PRESET, {8'h00, PRESET_FAILSAFE});
		rdc("cmd reload", REG_CMD_SRC_BASE, 16'h0010);
		wr(REG_DISC_TOL, 16'h0002);
		wr(REG_IRQ_ENABLE, 16'h0001);
		pair <= 1'b1;
		lvl <= 7'h00;
		wt(80);
		chk("sto disabled", 16'(safe_torque_off), 16'h0000);
		wr(REG_SAFE_CTRL, 16'h0001);
		wt(4);
		chk("sto low", 16'(safe_torque_off), 16'h0001);
		skew <= 6'd40;
		lvl <= 7'h10;
		wt(100);
		chk("sto high", 16'(safe_torque_off), 16'h0000);
		chk("skew", 16'(safe_input_fault), 16'h0000);
		brk <= 1'b1;
		wt(450);
		chk("fault", 16'(safe_input_fault), 16'h0001);
		chk("sto fault", 16'(safe_torque_off), 16'h0001);
		chk("irq", 16'(irq), 16'h0001);
		rdc("irq status", REG_IRQ_STATUS, 16'h0007);
		brk <= 1'b0;
		wt(80);
		chk("fault gone", 16'(safe_input_fault), 16'h0000);
		wr(REG_IRQ_CLEAR, 16'h0007);
		wt(3);
		chk("irq clear", 16'(irq), 16'h0000);
		rdc("irq cleared", REG_IRQ_STATUS, 16'h0000);
		$display("Test fail-safe pair done");
		complete_run();
	end
endmodule
`default_nettype wire
